// ### core/cell_state_map.svh
// Bit positions, reset values and timing counts of the cell state word
`ifndef CELL_STATE_MAP_SVH
`define CELL_STATE_MAP_SVH

`define CSW_EMPTY_BIT 0
`define CSW_FULL_BIT 1
`define CSW_TYPE_BIT 17
`define CSW_PTR_LSB 18
`define CSW_PTR_MSB 20
`define CSW_RSVD_HI 27
`define CSW_DEPTH_LSB 28
`define CSW_DEPTH_MSB 29
`define CSW_RSVD_TOP_LSB 30
`define CSW_RSVD_LOW_LSB 2
`define CSW_RSVD_LOW_MSB 16

`define CSW_RESET_FULL 1'b0
`define CSW_RESET_EMPTY 1'b1
`define CSW_RESET_PTR 3'h0
`define CSW_RESET_COUNT 4'h0

// Control view answers on the edge after the request
`define CSW_READ_LATENCY 1

`endif

// ### core/cell_state_pkg.sv
// Types shared by the cell state word logic
package cell_state_pkg;

  typedef enum logic [3:0] {
    VIEW_BYPASS = 4'b0000,
    VIEW_CONTROL = 4'b0001,
    VIEW_EF_SYNC = 4'b0010,
    VIEW_EF_TRY = 4'b0011,
    VIEW_PV_SYNC = 4'b0100,
    VIEW_PV_TRY = 4'b0101,
    VIEW_ICR = 4'b1111
  } view_e;

  typedef struct packed {
    logic valid;
    logic write;
    view_e view;
    logic upper;
    logic wide;
    logic [63:0] wdata;
  } ctrl_req_s;

  typedef struct packed {
    logic [3:0] count;
    logic [2:0] rd_ptr;
    logic full;
    logic empty;
    logic rsp_valid;
    logic [63:0] rsp_data;
  } cell_state_s;

endpackage

// ### core/cell_word_pack.sv
// Assembles the 64-bit cell state word from its fields
`timescale 1ns/1ps
`default_nettype none
`include "cell_state_map.svh"

module cell_word_pack
  import cell_state_pkg::*;
(
  input wire logic multi, // Cell built as multi-entry
  input wire logic [1:0] depth_exp, // Effective depth exponent
  input wire logic [2:0] rd_ptr, // Oldest entry pointer
  input wire logic full, // Full flag
  input wire logic empty, // Empty flag
  output logic [63:0] word // Packed state word
);

  logic [2:0] ptr_mask;

  always_comb
  begin
    case (depth_exp)
      2'b10: ptr_mask = 3'h3;
      2'b11: ptr_mask = 3'h7;
      default: ptr_mask = 3'h1;
    endcase
  end

  // Everything not set below stays zero, reserved bits included
  always_comb
  begin
    word = 64'h0000_0000_0000_0000;
    word[`CSW_DEPTH_MSB:`CSW_DEPTH_LSB] = depth_exp;
    word[`CSW_PTR_MSB:`CSW_PTR_LSB] = rd_ptr & ptr_mask;
    word[`CSW_TYPE_BIT] = multi;
    word[`CSW_FULL_BIT] = full;
    word[`CSW_EMPTY_BIT] = empty;
  end

endmodule
`default_nettype wire

// ### core/comm_cell_state_word.sv
// State and control word of one thread_comm_unit cell
//
// Notes on behaviour
// - Control view access returns the state word instead of cell data.
// - Bits 29:28 hold depth exponent; depth is two to that power.
// - Single-element cell always reports depth exponent zero.
// - Pointer from bit 18 names the oldest entry, read next.
// - Single-element or two-entry cell: pointer is bit 18 only.
// - One-bit pointer: 0 selects the odd entry, 1 the even entry.
// - Four entries use bits 19:18, eight entries use bits 20:18.
// - Reserved bits above the pointer, up to bit 27, read zero.
// - Bit 17 is cell kind: 0 single entry, 1 multi-entry FIFO.
// - Single-entry cell reports full once it stores valid data, until a removal or a low-word control view store.
// - Multi-entry cell reports full at maximum entry count, or when a low-word control view store sets the flag.
// - Empty flag in bit 0 is set when no valid data is held.
// - Control view accesses never block the requesting thread.
// - Bypass view accesses leave the state word unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "cell_state_map.svh"

module comm_cell_state_word
  import cell_state_pkg::*;
#(
  parameter logic MULTI_ENTRY = 1'b1, // Cell kind, fixed at build
  parameter logic [1:0] DEPTH_EXP = 2'b11 // Depth exponent when multi-entry
)
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire ctrl_req_s req, // Load or store from a thread
  output logic req_ready, // Always ready, never blocks
  output logic rsp_valid, // Read data valid, one cycle
  output logic [63:0] rsp_data, // Read data, registered
  input wire logic entry_push, // Data path stores one entry
  input wire logic entry_pop, // Data path removes oldest entry
  output logic push_taken, // Store accepted this cycle
  output logic pop_taken, // Removal accepted this cycle
  output logic [2:0] oldest_entry_pointer, // Entry that the next read returns
  output logic oldest_entry_odd, // Oldest entry is odd, narrow pointer only
  output logic cell_full, // Full flag
  output logic cell_empty // Empty flag
);

  // ****************************************
  // Build-time shape
  // ****************************************

  // A single-element cell ignores the exponent parameter
  localparam logic [1:0] EFF_EXP = MULTI_ENTRY ? DEPTH_EXP : 2'b00;
  localparam logic [3:0] MAX_COUNT = 4'(1 << EFF_EXP);
  localparam logic [2:0] PTR_MASK = (EFF_EXP == 2'b11) ? 3'h7 :
                                    (EFF_EXP == 2'b10) ? 3'h3 : 3'h1;

  cell_state_s st;
  cell_state_s next_st;
  logic [63:0] state_word;
  logic ctrl_hit;
  logic ctrl_wr_low;
  logic [3:0] cnt_after;

  cell_word_pack u_pack
  (
    .multi(MULTI_ENTRY),
    .depth_exp(EFF_EXP),
    .rd_ptr(st.rd_ptr),
    .full(st.full),
    .empty(st.empty),
    .word(state_word)
  );

  // ****************************************
  // Access decode
  // ****************************************

  assign req_ready = 1'b1;
  assign ctrl_hit = req.valid && (req.view == VIEW_CONTROL);
  // Upper-word-only stores carry no flag bits
  assign ctrl_wr_low = ctrl_hit && req.write && (req.wide || !req.upper);

  // Count guards keep a software-forced flag from wrapping the count
  assign push_taken = entry_push && ce && !st.full && (st.count != MAX_COUNT);
  assign pop_taken = entry_pop && ce && !st.empty && (st.count != 4'h0);
  assign cnt_after = st.count + {3'b000, push_taken} - {3'b000, pop_taken};

  // ****************************************
  // Next state
  // ****************************************

  always_comb
  begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    // Bypass and data views never reach this state
    if (ctrl_hit && !req.write)
    begin
      next_st.rsp_valid = 1'b1;
      if (!req.wide && req.upper)
      begin
        next_st.rsp_data = {32'h0000_0000, state_word[63:32]};
      end
      else
      begin
        next_st.rsp_data = state_word;
      end
    end
    if (ctrl_wr_low)
    begin
      next_st.full = req.wdata[`CSW_FULL_BIT];
      next_st.empty = req.wdata[`CSW_EMPTY_BIT];
    end
    // A data event in the same cycle wins over a software write
    if (push_taken || pop_taken)
    begin
      next_st.count = cnt_after;
      next_st.full = (cnt_after == MAX_COUNT);
      next_st.empty = (cnt_after == 4'h0);
    end
    if (pop_taken)
    begin
      next_st.rd_ptr = (st.rd_ptr + 3'h1) & PTR_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.count <= `CSW_RESET_COUNT;
      st.rd_ptr <= `CSW_RESET_PTR;
      st.full <= `CSW_RESET_FULL;
      st.empty <= `CSW_RESET_EMPTY;
      st.rsp_valid <= 1'b0;
      st.rsp_data <= 64'h0000_0000_0000_0000;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign rsp_valid = st.rsp_valid;
  assign rsp_data = st.rsp_data;
  assign oldest_entry_pointer = st.rd_ptr & PTR_MASK;
  // Narrow pointer counts entries from one: zero names the odd entry
  assign oldest_entry_odd = (EFF_EXP <= 2'b01) && !st.rd_ptr[0];
  assign cell_full = st.full;
  assign cell_empty = st.empty;

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_ctrl_read;
    ce && req.valid && !req.write && req.view == VIEW_CONTROL && (req.wide || !req.upper);
  endsequence

  sequence s_last_pop;
    ce && pop_taken && !push_taken && st.count == 4'h1;
  endsequence

  sequence s_fill_last;
    ce && push_taken && !pop_taken && st.count == MAX_COUNT - 4'h1;
  endsequence

  sequence s_ctrl_upper_read;
    ce && req.valid && !req.write && req.view == VIEW_CONTROL && !req.wide && req.upper;
  endsequence

  sequence s_idle_flags;
    ce && !ctrl_wr_low && !push_taken && !pop_taken;
  endsequence

  AST_CTRL_READ: assert property (
    s_ctrl_read |=> rsp_valid && rsp_data == $past(state_word))
    else $error("Control read did not return the state word");

  AST_DEPTH_FIELD: assert property (
    state_word[`CSW_DEPTH_MSB:`CSW_DEPTH_LSB] == EFF_EXP
    && (MAX_COUNT == 4'h1 || MAX_COUNT == 4'h2 || MAX_COUNT == 4'h4 || MAX_COUNT == 4'h8))
    else $error("Depth field wrong");

  AST_SINGLE_DEPTH: assert property (
    !state_word[`CSW_TYPE_BIT] |-> state_word[`CSW_DEPTH_MSB:`CSW_DEPTH_LSB] == 2'b00)
    else $error("Single cell reports nonzero depth");

  AST_PTR_ADVANCE: assert property (
    ce && pop_taken |=> oldest_entry_pointer == (($past(st.rd_ptr) + 3'h1) & PTR_MASK))
    else $error("Pointer did not advance on removal");

  AST_PTR_RESERVED: assert property (
    (state_word[`CSW_PTR_MSB:`CSW_PTR_LSB] & ~PTR_MASK) == 3'h0
    && state_word[`CSW_RSVD_HI:21] == 7'h00)
    else $error("Reserved bits above pointer not zero");

  AST_ODD_SELECT: assert property (
    EFF_EXP <= 2'b01 |-> oldest_entry_odd == !state_word[`CSW_PTR_LSB])
    else $error("Odd entry select wrong");

  AST_TYPE_BIT: assert property (
    state_word[`CSW_TYPE_BIT] == MULTI_ENTRY)
    else $error("Cell kind bit wrong");

  AST_FULL_AT_MAX: assert property (
    s_fill_last |=> cell_full && !cell_empty && st.count == MAX_COUNT)
    else $error("Full not set at maximum count");

  AST_EMPTY_ON_DRAIN: assert property (
    s_last_pop |=> cell_empty && !cell_full)
    else $error("Empty not set after last removal");

  AST_FLAG_WRITE: assert property (
    ce && ctrl_wr_low && !push_taken && !pop_taken
    |=> cell_full == $past(req.wdata[`CSW_FULL_BIT])
    && cell_empty == $past(req.wdata[`CSW_EMPTY_BIT]))
    else $error("Flag write not stored");

  AST_RESERVED_ZERO: assert property (
    state_word[63:`CSW_RSVD_TOP_LSB] == 34'h0
    && state_word[`CSW_RSVD_LOW_MSB:`CSW_RSVD_LOW_LSB] == 15'h0000)
    else $error("Reserved bits not zero");

  AST_BYPASS_KEEPS: assert property (
    ce && req.valid && req.view == VIEW_BYPASS && !entry_push && !entry_pop
    |=> $stable(cell_full) && $stable(cell_empty) && $stable(oldest_entry_pointer))
    else $error("Bypass access changed state");

  // ****************************************
  // Checks on responses, readiness, flags, count and pointer
  // ****************************************

  AST_UPPER_READ: assert property (
    s_ctrl_upper_read
    |=> rsp_valid && rsp_data == {32'h0000_0000, $past(state_word[63:32])})
    else $error("Upper word read wrong");

  AST_READY: assert property (
    req_ready)
    else $error("Control view stalled a request");

  AST_NO_STRAY_RSP: assert property (
    ce && !(req.valid && !req.write && req.view == VIEW_CONTROL) |=> !rsp_valid)
    else $error("Response without a control read");

  AST_PTR_HOLD: assert property (
    ce && !pop_taken |=> $stable(oldest_entry_pointer))
    else $error("Pointer moved without a removal");

  AST_PTR_WIDTH: assert property (
    (oldest_entry_pointer & ~PTR_MASK) == 3'h0)
    else $error("Pointer wider than the depth allows");

  AST_ODD_WIDE: assert property (
    EFF_EXP > 2'b01 |-> !oldest_entry_odd)
    else $error("Odd select raised on a wide pointer");

  AST_FULL_REFUSES: assert property (
    cell_full |-> !push_taken)
    else $error("Store accepted while full");

  AST_EMPTY_REFUSES: assert property (
    cell_empty |-> !pop_taken)
    else $error("Removal accepted while empty");

  AST_COUNT_BOUND: assert property (
    st.count <= MAX_COUNT)
    else $error("Entry count above depth");

  AST_FULL_DROPS: assert property (
    ce && pop_taken && !push_taken |=> !cell_full)
    else $error("Full stayed set after a removal");

  AST_EMPTY_DROPS: assert property (
    ce && push_taken && !pop_taken |=> !cell_empty)
    else $error("Empty stayed set after a store");

  // Flags hold unless software or a data event moves them
  AST_FLAGS_HOLD: assert property (
    s_idle_flags |=> $stable(cell_full) && $stable(cell_empty))
    else $error("Flags changed with no cause");

  AST_UPPER_WRITE: assert property (
    ce && ctrl_hit && req.write && !req.wide && req.upper && !push_taken && !pop_taken
    |=> $stable(cell_full) && $stable(cell_empty))
    else $error("Upper word store changed the flags");

  AST_SINGLE_FULL: assert property (
    !MULTI_ENTRY && ce && push_taken && !pop_taken |=> cell_full)
    else $error("Single cell not full after a store");

  // Single cell: one-bit pointer toggles on each removal
  AST_SINGLE_TOGGLE: assert property (
    !MULTI_ENTRY && pop_taken |=> oldest_entry_pointer == {2'b00, !$past(oldest_entry_pointer[0])})
    else $error("Single cell pointer did not toggle");

endmodule
`default_nettype wire

// ### testbench/thread_port_model.sv
// Processor thread model issuing loads and stores to one cell
`timescale 1ns/1ps
`default_nettype none

module thread_port_model
  import cell_state_pkg::*;
(
  input wire logic ref_clk, // Bench clock
  output var ctrl_req_s req // Request towards the cell
);
  initial req = '0;

  // ************************************************************
  // One access, held for one edge; the cell never stalls
  // ************************************************************
  task automatic access(input logic wr, input view_e v, input logic up, input logic wd,
    input logic [63:0] d);
    @(negedge ref_clk);
    req = '{1'b1, wr, v, up, wd, d};
    @(negedge ref_clk);
    req.valid = 1'b0;
    // Released data inverted so a stale value cannot pass
    req.wdata = ~d;
  endtask
endmodule

`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the cell state word
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cell_state_pkg::*;
  logic ref_clk, sys_rst, ce, entry_push, entry_pop;
  ctrl_req_s req;
  logic req_ready, rsp_valid, push_taken, pop_taken, oldest_entry_odd, cell_full, cell_empty;
  logic [63:0] rsp_data;
  logic [2:0] oldest_entry_pointer;
  logic [2:0] ptr1;
  logic odd1, full1, empty1;
  logic [63:0] expq[$];
  int mismatches = 0;
  int cmp_count = 0;
  logic [1:0] ptr;
  logic [15:0] rnd = 16'h0025;

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Four-entry build so the two-bit pointer and its wrap are reached
  comm_cell_state_word #(.MULTI_ENTRY(1'b1), .DEPTH_EXP(2'b10)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .entry_push(entry_push),
    .entry_pop(entry_pop), .push_taken(push_taken), .pop_taken(pop_taken),
    .oldest_entry_pointer(oldest_entry_pointer), .oldest_entry_odd(oldest_entry_odd),
    .cell_full(cell_full), .cell_empty(cell_empty));

  // Single-element build beside it: one-bit pointer, odd select, ignored exponent
  comm_cell_state_word #(.MULTI_ENTRY(1'b0), .DEPTH_EXP(2'b11)) i_dut_single (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .req(req), .req_ready(),
    .rsp_valid(), .rsp_data(), .entry_push(entry_push), .entry_pop(entry_pop),
    .push_taken(), .pop_taken(), .oldest_entry_pointer(ptr1), .oldest_entry_odd(odd1),
    .cell_full(full1), .cell_empty(empty1));

  thread_port_model i_thr (.ref_clk(ref_clk), .req(req));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [63:0] word_of(input logic [1:0] p, input logic f, input logic e);
    logic [63:0] w;
    w = '0;
    w[29:28] = 2'h2;
    w[19:18] = p;
    w[17] = 1'b1;
    w[1:0] = {f, e};
    return w;
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string n, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic rd(input logic up, input logic wd, input logic [63:0] e);
    expq.push_back(e);
    i_thr.access(1'b0, VIEW_CONTROL, up, wd, 64'h0000_0000_0000_0000);
  endtask

  task automatic ev(input logic ps, input logic pp, input logic ok);
    @(negedge ref_clk);
    entry_push = ps;
    entry_pop = pp;
    #1;
    chk("taken", {63'h0, ok}, {63'h0, ps ? push_taken : pop_taken});
    @(negedge ref_clk);
    entry_push = 1'b0;
    entry_pop = 1'b0;
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Responses are one-cycle pulses, looked at between edges
  always @(negedge ref_clk)
    if (rsp_valid === 1'b1)
    begin
      if (expq.size() == 0)
        chk("stray response", 64'h0000_0000_0000_0000, rsp_data);
      else
        chk("rsp_data", expq.pop_front(), rsp_data);
    end

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    entry_push = 1'b0;
    entry_pop = 1'b0;
    ptr = 2'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("ready", 64'h0000_0000_0000_0001, {63'h0, req_ready});
    chk("full flag", 64'h0000_0000_0000_0000, {63'h0, cell_full});
    chk("empty flag", 64'h0000_0000_0000_0001, {63'h0, cell_empty});
    chk("narrow odd", 64'h0000_0000_0000_0001, {63'h0, odd1});
    rd(1'b0, 1'b1, word_of(2'h0, 1'b0, 1'b1));
    rd(1'b1, 1'b0, 64'h0000_0000_0000_0000);
    rd(1'b0, 1'b0, word_of(2'h0, 1'b0, 1'b1));
    repeat (2) ev(1'b1, 1'b0, 1'b1);
    chk("single full", 64'h0000_0000_0000_0001, {63'h0, full1});
    repeat (2) ev(1'b0, 1'b1, 1'b1);
    chk("narrow pointer", 64'h0000_0000_0000_0001, {61'h0, ptr1});
    chk("narrow odd", 64'h0000_0000_0000_0000, {63'h0, odd1});
    chk("single empty", 64'h0000_0000_0000_0001, {63'h0, empty1});
    ptr = 2'h2;
    for (int i = 0; i < 4; i++)
    begin
      ev(1'b1, 1'b0, 1'b1);
      if (i == 2)
        rd(1'b0, 1'b1, word_of(ptr, 1'b0, 1'b0));
    end
    rd(1'b0, 1'b1, word_of(ptr, 1'b1, 1'b0));
    ev(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      ev(1'b0, 1'b1, 1'b1);
      ptr = ptr + 2'h1;
      chk("pointer", {62'h0, ptr}, {61'h0, oldest_entry_pointer});
      rd(1'b0, 1'b1, word_of(ptr, 1'b0, i == 3));
    end
    ev(1'b0, 1'b1, 1'b0);
    i_thr.access(1'b1, VIEW_CONTROL, 1'b0, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(1'b0, 1'b1, word_of(ptr, 1'b1, 1'b1));
    i_thr.access(1'b1, VIEW_BYPASS, 1'b0, 1'b1, 64'h0000_0000_0000_0000);
    i_thr.access(1'b0, VIEW_BYPASS, 1'b0, 1'b1, 64'h0000_0000_0000_0000);
    rd(1'b0, 1'b1, word_of(ptr, 1'b1, 1'b1));
    // Semaphore set-up clears both flags
    i_thr.access(1'b1, VIEW_CONTROL, 1'b0, 1'b1, 64'h0000_0000_0000_0000);
    i_thr.access(1'b1, VIEW_CONTROL, 1'b1, 1'b0, 64'h0000_0000_0000_0003);
    rd(1'b0, 1'b1, word_of(ptr, 1'b0, 1'b0));
    // A frozen cell holds its response pulse, so let the last one pass first
    @(negedge ref_clk);
    ce = 1'b0;
    i_thr.access(1'b0, VIEW_CONTROL, 1'b0, 1'b1, 64'h0000_0000_0000_0000);
    ce = 1'b1;
    repeat (6)
    begin
      rnd = lfsr(rnd);
      i_thr.access(1'b1, VIEW_CONTROL, 1'b0, 1'b1, {4{rnd}});
      rd(1'b0, 1'b1, word_of(ptr, rnd[1], rnd[0]));
    end
    // Second reset in mid-run, with the pointer away from its reset value and the flags back at their reset values
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("pointer after reset", 64'h0000_0000_0000_0000, {61'h0, oldest_entry_pointer});
    chk("single empty", 64'h0000_0000_0000_0001, {63'h0, empty1});
    chk("narrow odd", 64'h0000_0000_0000_0001, {63'h0, odd1});
    rd(1'b0, 1'b1, word_of(2'h0, 1'b0, 1'b1));
    i_thr.access(1'b1, VIEW_CONTROL, 1'b0, 1'b0, 64'h0000_0000_0000_0002);
    rd(1'b0, 1'b1, word_of(2'h0, 1'b1, 1'b0));
    repeat (3) @(negedge ref_clk);
    chk("pending responses", 64'h0000_0000_0000_0000, 64'(expq.size()));
    report_and_stop();
  end
endmodule

`default_nettype wire
